/* include/pdr_consts.svh */
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH
// register byte offsets
`define PDR_CTRL_OFS 4'h0
`define PDR_STAT_OFS 4'h4
`define PDR_IRQ_OFS 4'h8
`define PDR_MASK_OFS 4'hC
// control field positions
`define PDR_CTRL_START_BIT 0
`define PDR_CTRL_STOP_BIT 1
`define PDR_CTRL_HEAT_BIT 2
`define PDR_CTRL_FLTINV_BIT 3
`define PDR_CTRL_LOADSEL_BIT 4
// reset values
`define PDR_CTRL_RST 8'h00
`define PDR_MASK_RST 4'h0
// debounce time in ns and derived cycle count at 100 MHz
`define PDR_DEB_NS 1000000
`define PDR_CLK_NS 10
`define PDR_DEB_CYC ((`PDR_DEB_NS + `PDR_CLK_NS - 1) / `PDR_CLK_NS)
`endif

/* include/pdr_pkg.sv */
package pdr_pkg;
    typedef enum logic [2:0] {
        PDR_STANDSTILL = 3'b000,
        PDR_DELAY = 3'b001,
        PDR_RELAY_A = 3'b010,
        PDR_NORMAL = 3'b011,
        PDR_OVERLOAD = 3'b100,
        PDR_BRAKE = 3'b101,
        PDR_FAULT_TURN = 3'b110,
        PDR_FAULT_STILL = 3'b111
    } pdr_state_t;
endpackage

/* hdl/pdr_relay_seq.sv */
`timescale 1ns/1ps
`include "pdr_consts.svh"
module pdr_relay_seq #(
    parameter int DEB_CYC = `PDR_DEB_CYC,
    parameter int VAL_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // remote terminal inputs (pins)
    input wire logic remote_select_input,
    input wire logic remote_start_input,
    input wire logic remote_stop_b_input,
    input wire logic flange_heat_request,
    // front panel keys (pins)
    input wire logic key_start,
    input wire logic key_stop,
    input wire logic key_heat,
    // pump status from drive (same clock)
    input wire logic drive_fault,
    input wire logic rotor_still,
    input wire logic delay_done,
    input wire logic at_speed,
    input wire logic min_speed_ok,
    input wire logic [VAL_W-1:0] motor_current,
    input wire logic [VAL_W-1:0] rotor_speed,
    input wire logic dip_load_sel,
    // outputs
    output logic [VAL_W-1:0] analog_value,
    output logic vent_valve_output,
    output logic heater_output,
    output logic cooling_output,
    output logic backing_pump_output,
    output logic relay_a,
    output logic fault_relay,
    output logic at_speed_relay,
    output logic valve_heater_output,
    output logic drive_enable
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers and debounce for all seven pins

    localparam int NIN = 7;
    localparam int CW = $clog2(DEB_CYC + 1);
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    logic [NIN-1:0] deb_reg;
    assign pin_raw = {key_heat, key_stop, key_start, flange_heat_request,
                      remote_stop_b_input, remote_start_input, remote_select_input};

    // two flops; first is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else if (clk_en) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // a level is accepted only after it stayed stable for the whole window
    // the price is DEB_CYC cycles of delay, and a pulse shorter than that is lost
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_deb
            logic [CW-1:0] cnt_reg;
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_reg <= '0;
                    deb_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (sync2_reg[gi] == deb_reg[gi]) begin
                        cnt_reg <= '0;
                    end else if (cnt_reg == CW'(DEB_CYC - 1)) begin
                        cnt_reg <= '0;
                        deb_reg[gi] <= sync2_reg[gi];
                    end else begin
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                end
            end
        end
    endgenerate

    logic rem_sel, rem_start, rem_stop_b, rem_heat, k_start, k_stop, k_heat;
    assign {k_heat, k_stop, k_start, rem_heat, rem_stop_b, rem_start, rem_sel} = deb_reg;

////////////////////////////////////////////////////////////////////////////////
// registers

    logic [7:0] ctrl_reg;
    logic [3:0] irq_reg;
    logic [3:0] mask_reg;
    logic [3:0] irq_ev;
    logic heat_sel_reg;
    pdr_pkg::pdr_state_t state_reg;
    pdr_pkg::pdr_state_t state_next;
    logic wr_ctrl;
    logic wr_irq;
    logic rd_ack_reg;
    // a read waits one cycle so readdata can come from a flop and still stand at the accepting edge;
    // while the clock enable is low every access is held off, or a write would be acknowledged and lost
    assign waitrequest = (read && !rd_ack_reg) || ((read || write) && !clk_en);
    assign wr_ctrl = write && address == `PDR_CTRL_OFS;
    assign wr_irq = write && address == `PDR_IRQ_OFS;

    // control and mask; start/stop bits are self-clearing command pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= `PDR_CTRL_RST;
            mask_reg <= `PDR_MASK_RST;
        end else if (clk_en) begin
            ctrl_reg[`PDR_CTRL_START_BIT] <= 1'b0;
            ctrl_reg[`PDR_CTRL_STOP_BIT] <= 1'b0;
            if (wr_ctrl)
                ctrl_reg <= writedata[7:0];
            if (write && address == `PDR_MASK_OFS)
                mask_reg <= writedata[3:0];
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 4'h0;
        end else if (clk_en) begin
            irq_reg <= (irq_reg & ~(wr_irq ? writedata[3:0] : 4'h0)) | irq_ev;
        end
    end
    assign irq = |(irq_reg & mask_reg);

    // read wait state: high in the second cycle of a read, low again once the master has taken the data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ack_reg <= 1'b0;
        end else if (clk_en) begin
            rd_ack_reg <= read && !rd_ack_reg;
        end
    end

    // read mux, loaded in the wait-state cycle; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (clk_en && read && !rd_ack_reg) begin
            unique case (address)
                `PDR_CTRL_OFS: readdata <= {24'h0, ctrl_reg};
                `PDR_STAT_OFS: readdata <= {26'h0, heat_sel_reg, rem_sel, 1'b0, state_reg};
                `PDR_IRQ_OFS: readdata <= {28'h0, irq_reg};
                `PDR_MASK_OFS: readdata <= {28'h0, mask_reg};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// command selection: remote inputs or panel keys plus software

    // panel keys and software start/stop share one path; a held key behaves like a repeated command
    logic cmd_start, cmd_stop, cmd_heat_on, cmd_heat_tgl, k_heat_d_reg;
    // remote stop is active low and dominant over start
    assign cmd_stop = rem_sel ? !rem_stop_b : (k_stop || ctrl_reg[`PDR_CTRL_STOP_BIT]);
    assign cmd_start = rem_sel ? (rem_start && rem_stop_b)
                               : (k_start || ctrl_reg[`PDR_CTRL_START_BIT]);
    assign cmd_heat_on = rem_heat;
    assign cmd_heat_tgl = k_heat && !k_heat_d_reg;

    // heating selection: remote level, or panel key toggles, or software bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            k_heat_d_reg <= 1'b0;
            heat_sel_reg <= 1'b0;
        end else if (clk_en) begin
            k_heat_d_reg <= k_heat;
            if (rem_sel)
                heat_sel_reg <= cmd_heat_on;
            else if (cmd_heat_tgl)
                heat_sel_reg <= !heat_sel_reg;
            else if (wr_ctrl)
                heat_sel_reg <= writedata[`PDR_CTRL_HEAT_BIT];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// operating state machine

    // stop and drive faults are tested before any progress, so they always win over start
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pdr_pkg::PDR_STANDSTILL:
                if (drive_fault) state_next = pdr_pkg::PDR_FAULT_STILL;
                else if (cmd_start && !cmd_stop) state_next = pdr_pkg::PDR_DELAY;
            pdr_pkg::PDR_DELAY:
                if (drive_fault) state_next = pdr_pkg::PDR_FAULT_TURN;
                else if (cmd_stop) state_next = pdr_pkg::PDR_BRAKE;
                else if (delay_done) state_next = pdr_pkg::PDR_RELAY_A;
            pdr_pkg::PDR_RELAY_A, pdr_pkg::PDR_NORMAL, pdr_pkg::PDR_OVERLOAD:
                if (drive_fault) state_next = pdr_pkg::PDR_FAULT_TURN;
                else if (cmd_stop) state_next = pdr_pkg::PDR_BRAKE;
                else if (at_speed) state_next = pdr_pkg::PDR_NORMAL;
                else if (min_speed_ok) state_next = pdr_pkg::PDR_OVERLOAD;
                else if (state_reg != pdr_pkg::PDR_RELAY_A) state_next = pdr_pkg::PDR_FAULT_TURN;
            pdr_pkg::PDR_BRAKE:
                if (drive_fault) state_next = pdr_pkg::PDR_FAULT_TURN;
                else if (rotor_still) state_next = pdr_pkg::PDR_STANDSTILL;
            pdr_pkg::PDR_FAULT_TURN:
                if (rotor_still) state_next = pdr_pkg::PDR_FAULT_STILL;
            pdr_pkg::PDR_FAULT_STILL:
                // only a stop clears it, and only once the cause is gone
                if (cmd_stop && !drive_fault && rotor_still) state_next = pdr_pkg::PDR_STANDSTILL;
        endcase
    end

    // clock enable low holds the state, as it holds every other flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            state_reg <= pdr_pkg::PDR_STANDSTILL;
        else if (clk_en)
            state_reg <= state_next;
    end

    // state decodes shared by the event flags, the relay drive and the drive enable
    function automatic logic is_fault(input pdr_pkg::pdr_state_t st);
        return st == pdr_pkg::PDR_FAULT_TURN || st == pdr_pkg::PDR_FAULT_STILL;
    endfunction

    function automatic logic is_up_to_speed(input pdr_pkg::pdr_state_t st);
        return st == pdr_pkg::PDR_NORMAL || st == pdr_pkg::PDR_OVERLOAD;
    endfunction

    // events: entered fault, reached normal, reached standstill, fault cleared
    logic in_fault;
    assign in_fault = is_fault(state_next);
    assign irq_ev = {state_reg == pdr_pkg::PDR_FAULT_STILL && state_next == pdr_pkg::PDR_STANDSTILL,
                     state_reg != pdr_pkg::PDR_STANDSTILL && state_next == pdr_pkg::PDR_STANDSTILL,
                     state_reg != pdr_pkg::PDR_NORMAL && state_next == pdr_pkg::PDR_NORMAL,
                     in_fault && !is_fault(state_reg)}
                    & {4{clk_en}};

////////////////////////////////////////////////////////////////////////////////
// relay outputs, registered from the next state

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vent_valve_output <= 1'b0;
            heater_output <= 1'b0;
            cooling_output <= 1'b0;
            backing_pump_output <= 1'b0;
            relay_a <= 1'b0;
            fault_relay <= 1'b0;
            at_speed_relay <= 1'b0;
            drive_enable <= 1'b0;
            valve_heater_output <= 1'b0;
            analog_value <= '0;
        end else if (clk_en) begin
            unique case (state_next)
                pdr_pkg::PDR_DELAY:
                    {vent_valve_output, cooling_output, backing_pump_output, relay_a, at_speed_relay} <= 5'b10110;
                pdr_pkg::PDR_RELAY_A:
                    {vent_valve_output, cooling_output, backing_pump_output, relay_a, at_speed_relay} <= 5'b11110;
                pdr_pkg::PDR_NORMAL, pdr_pkg::PDR_OVERLOAD:
                    {vent_valve_output, cooling_output, backing_pump_output, relay_a, at_speed_relay} <= 5'b11101;
                pdr_pkg::PDR_BRAKE, pdr_pkg::PDR_FAULT_TURN:
                    {vent_valve_output, cooling_output, backing_pump_output, relay_a, at_speed_relay} <= 5'b01100;
                default:
                    {vent_valve_output, cooling_output, backing_pump_output, relay_a, at_speed_relay} <= 5'b00000;
            endcase
            heater_output <= heat_sel_reg && is_up_to_speed(state_next);
            // normally closed unless inverted by the option bit
            fault_relay <= !in_fault ^ ctrl_reg[`PDR_CTRL_FLTINV_BIT];
            // motor drive only while accelerating or at speed; braking is left to the drive itself
            drive_enable <= state_next == pdr_pkg::PDR_RELAY_A || is_up_to_speed(state_next);
            valve_heater_output <= 1'b1;
            analog_value <= (dip_load_sel || ctrl_reg[`PDR_CTRL_LOADSEL_BIT])
                            ? motor_current : rotor_speed;
        end
    end

endmodule // pdr_relay_seq

/* test/pdr_relay_seq_props.sv */
`timescale 1ns/1ps
module pdr_relay_seq_props #(
    parameter int DEB_CYC = 4,
    parameter int VAL_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic remote_select_input,
    input wire logic remote_stop_b_input,
    input wire logic drive_fault,
    input wire logic rotor_still,
    input wire logic [VAL_W-1:0] motor_current,
    input wire logic dip_load_sel,
    input wire logic [VAL_W-1:0] analog_value,
    input wire logic vent_valve_output,
    input wire logic heater_output,
    input wire logic cooling_output,
    input wire logic backing_pump_output,
    input wire logic relay_a,
    input wire logic fault_relay,
    input wire logic at_speed_relay,
    input wire logic valve_heater_output
);
    int stop_cnt_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    // cycles of remote stop held; sync and filter latency must pass before braking is demanded
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            stop_cnt_reg <= 0;
        else if (clk_en && remote_select_input && !remote_stop_b_input)
            stop_cnt_reg <= stop_cnt_reg + 1;
        else
            stop_cnt_reg <= 0;
    end
    ////////////////////////////////////////////////////////////
    // relay checks assume the fault relay is not inverted while the pump runs
    AST_ANALOG: assert property ($past(rst_b) && $past(clk_en) && $past(dip_load_sel) |-> analog_value == $past(motor_current))
        else $error("analog value not following motor current");
    AST_VALVE_HEAT: assert property ($past(rst_b) |-> valve_heater_output)
        else $error("valve heater off while powered");
    AST_STOP_DOM: assert property (stop_cnt_reg > DEB_CYC + 8 |-> !vent_valve_output && !relay_a && !at_speed_relay)
        else $error("run relays closed under held stop");
    AST_FAULT_OPEN: assert property ($rose(drive_fault) |-> ##[1:4] (!vent_valve_output && !relay_a && !at_speed_relay))
        else $error("run relays still closed after fault");
    AST_FAULT_HOLD: assert property ($past(rst_b) && !fault_relay && !rotor_still |=> !fault_relay)
        else $error("fault left while rotor turning");
    AST_CLOSED: assert property ($past(rst_b) && (vent_valve_output || relay_a) |-> fault_relay)
        else $error("fault relay open in running state");
    AST_RELAY_A_EXCL: assert property (relay_a |-> vent_valve_output && backing_pump_output && !at_speed_relay && !heater_output)
        else $error("acceleration relay pattern wrong");
    AST_HEAT: assert property (heater_output |-> at_speed_relay && cooling_output)
        else $error("heater on outside normal operation");
    AST_PUMP: assert property ((cooling_output || vent_valve_output) |-> backing_pump_output)
        else $error("backing pump open while cooling or valve closed");
endmodule // pdr_relay_seq_props
bind pdr_relay_seq pdr_relay_seq_props #(.DEB_CYC(DEB_CYC), .VAL_W(VAL_W)) u_props (.*);

/* test/pdr_remote_panel.sv */
`timescale 1ns/1ps
module pdr_remote_panel #(
    parameter int PULSE_CYC = 12
) (
    input wire logic clk,
    input wire logic cmd_select,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_heat,
    output logic remote_select_input = 1'b0,
    output logic remote_start_input = 1'b0,
    output logic remote_stop_b_input = 1'b1,
    output logic flange_heat_request = 1'b0
);
    int pulse_cnt = 0;
    ////////////////////////////////////////////////////////////
    // select and heating are steady levels; no reset here, the panel outlives device power
    always @(posedge clk) begin
        remote_select_input <= cmd_select;
        flange_heat_request <= cmd_heat;
        remote_stop_b_input <= !cmd_stop; // active low stop
    end
    // start is stretched so an impulse outlasts the input filter; held command gives a steady level
    always @(posedge clk) begin
        if (cmd_start)
            pulse_cnt <= PULSE_CYC;
        else if (pulse_cnt > 0)
            pulse_cnt <= pulse_cnt - 1;
        remote_start_input <= cmd_start || pulse_cnt > 1;
    end
endmodule // pdr_remote_panel

/* test/pdr_relay_seq_tb_top.sv */
`timescale 1ns/1ps
`include "pdr_consts.svh"
module pdr_relay_seq_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, read = 1'b0, write = 1'b0, irq, waitrequest;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic cmd_select = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_heat = 1'b0;
    logic remote_select_input, remote_start_input, remote_stop_b_input, flange_heat_request;
    logic key_start = 1'b0, key_stop = 1'b0, key_heat = 1'b0, dip_load_sel = 1'b0, drive_fault = 1'b0;
    logic rotor_still = 1'b1, delay_done = 1'b0, at_speed = 1'b0, min_speed_ok = 1'b0;
    logic [11:0] motor_current = 12'hA5C, rotor_speed = 12'h3C1, analog_value;
    logic vent_valve_output, heater_output, cooling_output, backing_pump_output, relay_a, fault_relay;
    logic at_speed_relay, valve_heater_output, drive_enable;
    logic [6:0] relays;
    int errors = 0, tests_run = 0;
    assign relays = {vent_valve_output, heater_output, cooling_output, backing_pump_output, relay_a, fault_relay,
        at_speed_relay};
    // short filter so every pin command settles in a handful of cycles
    pdr_relay_seq #(.DEB_CYC(4)) DUT (.*);
    pdr_remote_panel u_panel (.*);
    ////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until waitrequest is seen low; one idle edge keeps strobes from being reassigned
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge clk);
    endtask
    // read data is taken at the very edge that sees waitrequest low, then the request is released
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic expect_relays(input string what, input logic [6:0] exp);
        for (int i = 0; i < 40 && relays !== exp; i++)
            @(posedge clk);
        chk(what, {25'h0, exp}, {25'h0, relays});
    endtask
    task automatic stop_pulse();
        cmd_stop <= 1'b1;
        repeat (12) @(posedge clk);
        cmd_stop <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    // relay words are {valve, heater, cooling, pump, relay_a, fault, at speed}
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        expect_relays("idle relays", 7'h02);
        chk("valve heater", 32'h1, 32'(valve_heater_output));
        bus_rd(4'h2, rd);
        chk("unmapped", 32'h0, rd);
        bus_rd(`PDR_MASK_OFS, rd);
        chk("mask reset", 32'h0, rd);
        dip_load_sel <= 1'b1;
        repeat (2) @(posedge clk);
        chk("analog current", 32'hA5C, 32'(analog_value));
        dip_load_sel <= 1'b0;
        repeat (2) @(posedge clk);
        chk("analog speed", 32'h3C1, 32'(analog_value));
        bus_wr(`PDR_CTRL_OFS, 32'h10);
        repeat (2) @(posedge clk);
        chk("analog by option", 32'hA5C, 32'(analog_value));
        bus_wr(`PDR_CTRL_OFS, 32'h0);
        clk_en <= 1'b0;
        dip_load_sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk("analog frozen", 32'h3C1, 32'(analog_value));
        clk_en <= 1'b1;
        dip_load_sel <= 1'b0;
        cmd_select <= 1'b1;
        repeat (12) @(posedge clk);
        key_start <= 1'b1;
        repeat (12) @(posedge clk);
        key_start <= 1'b0;
        repeat (8) @(posedge clk);
        expect_relays("keys ignored", 7'h02);
        bus_wr(`PDR_MASK_OFS, 32'h2);
        rotor_still <= 1'b0;
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        expect_relays("delay relays", 7'h4E);
        delay_done <= 1'b1;
        expect_relays("relay_a relays", 7'h5E);
        chk("drive enable run", 32'h1, 32'(drive_enable));
        cmd_heat <= 1'b1;
        at_speed <= 1'b1;
        min_speed_ok <= 1'b1;
        expect_relays("normal heated", 7'h7B);
        bus_rd(`PDR_STAT_OFS, rd);
        chk("normal state", 32'h3, rd & 32'h7);
        chk("remote and heat flags", 32'h30, rd & 32'h30);
        chk("irq raised", 32'h1, 32'(irq));
        bus_wr(`PDR_IRQ_OFS, 32'hF);
        chk("irq cleared", 32'h0, 32'(irq));
        cmd_heat <= 1'b0;
        expect_relays("heat off", 7'h5B);
        cmd_stop <= 1'b1;
        cmd_start <= 1'b1;
        expect_relays("stop over start", 7'h1A);
        chk("drive enable braking", 32'h0, 32'(drive_enable));
        rotor_still <= 1'b1;
        expect_relays("stopped", 7'h02);
        cmd_start <= 1'b0;
        repeat (20) @(posedge clk);
        cmd_stop <= 1'b0;
        repeat (10) @(posedge clk);
        rotor_still <= 1'b0;
        at_speed <= 1'b0;
        min_speed_ok <= 1'b0;
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        expect_relays("restart", 7'h5E);
        drive_fault <= 1'b1;
        expect_relays("fault turning", 7'h18);
        chk("irq masked", 32'h0, 32'(irq));
        rotor_still <= 1'b1;
        expect_relays("fault still", 7'h00);
        stop_pulse();
        expect_relays("fault kept", 7'h00);
        drive_fault <= 1'b0;
        stop_pulse();
        expect_relays("fault cleared", 7'h02);
        bus_rd(`PDR_IRQ_OFS, rd);
        chk("irq status", 32'hD, rd);
        bus_wr(`PDR_CTRL_OFS, 32'h8);
        expect_relays("fault relay inverted", 7'h00);
        bus_wr(`PDR_CTRL_OFS, 32'h0);
        rst_b <= 1'b0;
        rotor_still <= 1'b0;
        delay_done <= 1'b0;
        cmd_start <= 1'b1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        expect_relays("power-on start", 7'h4E);
        tally_and_finish();
    end
endmodule // pdr_relay_seq_tb_top
